// File: logic/tpc_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpc_defines.svh"

// Operation
// [R01] Edge/level code 00 releases the pin from every timer function.
// [R02] Capture mode: code 01 rising, 10 falling, 11 either edge.
// [R03] Compare mode: 00 software only, 01 toggle, 10 clear, 11 set pin.
// [R04] Edge PWM: code 10 high-true pulses, X1 low-true pulses.
// [R05] Center PWM: code 10 high-true, X1 low-true, on up-count compare.
// [R06] Channel value is readable, writable and cleared by reset.
// [R07] Capture mode reads latch both bytes until the other byte is read.
// [R08] Any channel control write restarts read and write byte sequences.
// [R09] Writes to the channel value are ignored in capture mode.
// [R10] Debug freezes read latching; reads return live channel value.
// [R11] Byte writes go to a buffer; unclocked timer loads on second byte.
// [R12] Clocked compare mode loads the pair at the next counter step.
// [R13] Clocked PWM loads the pair when counter steps to its top value.
// [R14] Debug writes go straight to the active value, kept afterwards.
// [R15] Debug writes leave a partial buffered sequence intact.
// [R16] One shared 16-bit counter with clock source, prescaler and modulo.
// [R17] Center select makes the counter count up and down.
// [R18] Clock select: none, bus clock, fixed clock, external pin clock.
// [R19] Clock select resets to none and is always read/write.
// [R20] Stopping the clock leaves counter and registers unchanged.
// [R21] External clock passes a bus-clock synchroniser; at most quarter rate.
// [R22] Fixed clock is synchronised only when a clock loop is engaged.
// [R23] Capture edge stores the counter value and sets the channel flag.
// [R24] A debug-active input selects the debug access behaviour.
// [R25] Software should not capture on a pin that clocks the timer.
module tpc_channel (
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Register port.
  input  wire logic [2:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // Debug and clock sources.
  input  wire logic        i_debug_active,
  input  wire logic        i_ext_clk,
  input  wire logic        i_fixed_clk,
  input  wire logic        i_fll_engaged,
  // Channel pin.
  input  wire logic        i_ch_pin,
  output logic             o_ch_pin,
  output logic             o_ch_oe,
  output logic             o_ch_flag
);
  import tpc_pkg::*;

  tpc_state_t  st;
  tpc_state_t  next_st;
  tpc_ctl_if   ctl ();
  logic [15:0] top;
  logic        dbg;
  logic        is_ic;
  logic        wr_cv;
  logic        hi;
  logic        cap_evt;
  logic        cmp_hit;
  logic        pwm_step;

  tpc_clk_sel u_clk_sel (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_ext_clk     (i_ext_clk),
    .i_fixed_clk   (i_fixed_clk),
    .i_fll_engaged (i_fll_engaged),
    .ctl           (ctl.clk_src)
  );

  tpc_mode_dec u_mode_dec (
    .ctl (ctl.dec)
  );

  assign ctl.clks  = st.clks;
  assign ctl.presc = st.presc;
  assign ctl.center_pwm_select = st.center_pwm_select;
  assign ctl.ms    = st.ms;
  assign dbg       = i_debug_active; // [R24]
  assign is_ic     = (ctl.mode == TPC_M_IC);
  assign o_rdata   = st.rdata;
  assign o_ch_pin  = st.pin;
  assign o_ch_oe   = st.oe;
  assign o_ch_flag = st.flag;

  always_comb begin
    next_st  = st;
    top      = (st.modv == `TPC_MOD_RST) ? `TPC_FREE_TOP : st.modv;
    hi       = (i_addr == `TPC_A_CV_H);
    wr_cv    = i_wr && (hi || i_addr == `TPC_A_CV_L);
    cap_evt  = 1'b0;
    cmp_hit  = 1'b0;
    pwm_step = 1'b0;

    // Shared counter; with no clock selected nothing here moves.
    if (ctl.tick) begin // [R16] [R20]
      pwm_step = !st.down && (st.cnt == 16'(top - 16'h0001)); // [R13]
      if (st.center_pwm_select) begin // [R17]
        if (!st.down) begin
          if (st.cnt == top) begin
            next_st.down = (top != 16'h0000);
            next_st.cnt  = (top != 16'h0000) ? 16'(st.cnt - 16'h0001) : st.cnt;
          end else begin
            next_st.cnt = 16'(st.cnt + 16'h0001);
          end
        end else if (st.cnt == 16'h0000) begin
          next_st.down = 1'b0;
          next_st.cnt  = 16'h0001;
        end else begin
          next_st.cnt = 16'(st.cnt - 16'h0001);
        end
      end else begin
        next_st.cnt = (st.cnt == top) ? 16'h0000 : 16'(st.cnt + 16'h0001);
      end
      cmp_hit = (next_st.cnt == st.cv);
    end

    // Buffered value reaches the active register once the pair is complete.
    if (st.wr == TPC_WR_BOTH) begin
      if (ctl.mode == TPC_M_OC && ctl.tick) begin // [R12]
        next_st.cv = st.wbuf;
        next_st.wr = TPC_WR_NONE;
      end else if (ctl.mode != TPC_M_OC && ctl.mode != TPC_M_IC && pwm_step) begin // [R13]
        next_st.cv = st.wbuf;
        next_st.wr = TPC_WR_NONE;
      end
    end

    // Register writes.
    if (i_wr) begin
      case (i_addr)
        `TPC_A_TSC: begin
          next_st.center_pwm_select = i_wdata[`TPC_TSC_CENTER_PWM_SELECT];
          next_st.clks  = tpc_clks_t'(i_wdata[`TPC_TSC_CLKS]); // [R19]
          next_st.presc = i_wdata[`TPC_TSC_PRESC];
        end
        `TPC_A_CNT_H, `TPC_A_CNT_L: begin
          next_st.cnt  = 16'h0000;
          next_st.down = 1'b0;
        end
        `TPC_A_MOD_H: next_st.modv[15:8] = i_wdata;
        `TPC_A_MOD_L: next_st.modv[7:0] = i_wdata;
        `TPC_A_CSC: begin
          next_st.ie  = i_wdata[`TPC_CSC_IE];
          next_st.ms  = i_wdata[`TPC_CSC_MS];
          next_st.els = i_wdata[`TPC_CSC_ELS];
          if (st.arm && !i_wdata[`TPC_CSC_FLAG]) begin
            next_st.flag = 1'b0;
          end
          next_st.arm = 1'b0;
          next_st.wr  = TPC_WR_NONE; // [R08]
          next_st.rd  = TPC_RD_NONE; // [R08]
        end
        default: begin
        end
      endcase
    end

    // Channel value writes.
    if (wr_cv && !is_ic) begin // [R09]
      if (dbg) begin
        if (hi) begin
          next_st.cv[15:8] = i_wdata; // [R14] [R15]
        end else begin
          next_st.cv[7:0] = i_wdata; // [R14] [R15]
        end
      end else begin
        if (hi) begin
          next_st.wbuf[15:8] = i_wdata; // [R11]
        end else begin
          next_st.wbuf[7:0] = i_wdata; // [R11]
        end
        if (st.wr == (hi ? TPC_WR_LO : TPC_WR_HI)) begin
          if (st.clks == TPC_CK_NONE) begin
            next_st.cv = next_st.wbuf; // [R11]
            next_st.wr = TPC_WR_NONE;
          end else begin
            next_st.wr = TPC_WR_BOTH;
          end
        end else begin
          next_st.wr = hi ? TPC_WR_HI : TPC_WR_LO;
        end
      end
    end

    // Register reads; data stands in the following cycle only.
    next_st.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        `TPC_A_TSC: begin
          next_st.rdata[`TPC_TSC_CENTER_PWM_SELECT] = st.center_pwm_select;
          next_st.rdata[`TPC_TSC_CLKS]  = st.clks; // [R19]
          next_st.rdata[`TPC_TSC_PRESC] = st.presc;
        end
        `TPC_A_CNT_H: next_st.rdata = st.cnt[15:8];
        `TPC_A_CNT_L: next_st.rdata = st.cnt[7:0];
        `TPC_A_MOD_H: next_st.rdata = st.modv[15:8];
        `TPC_A_MOD_L: next_st.rdata = st.modv[7:0];
        `TPC_A_CSC: begin
          next_st.rdata[`TPC_CSC_FLAG] = st.flag;
          next_st.rdata[`TPC_CSC_IE]   = st.ie;
          next_st.rdata[`TPC_CSC_MS]   = st.ms;
          next_st.rdata[`TPC_CSC_ELS]  = st.els;
          next_st.arm                  = st.flag;
        end
        `TPC_A_CV_H: begin
          if (dbg || !is_ic) begin
            next_st.rdata = st.cv[15:8]; // [R10]
          end else if (st.rd == TPC_RD_NONE) begin
            next_st.rdata = st.cv[15:8]; // [R07]
            next_st.rbuf  = st.cv;
            next_st.rd    = TPC_RD_HI;
          end else begin
            next_st.rdata = st.rbuf[15:8]; // [R07]
            if (st.rd == TPC_RD_LO) begin
              next_st.rd = TPC_RD_NONE;
            end
          end
        end
        default: begin
          if (dbg || !is_ic) begin
            next_st.rdata = st.cv[7:0]; // [R10]
          end else if (st.rd == TPC_RD_NONE) begin
            next_st.rdata = st.cv[7:0]; // [R07]
            next_st.rbuf  = st.cv;
            next_st.rd    = TPC_RD_LO;
          end else begin
            next_st.rdata = st.rbuf[7:0]; // [R07]
            if (st.rd == TPC_RD_HI) begin
              next_st.rd = TPC_RD_NONE;
            end
          end
        end
      endcase
    end

    // Pin function and events; events are last so a set beats a clear.
    next_st.prev_in = i_ch_pin;
    next_st.oe      = (st.els != `TPC_ELS_OFF) && !is_ic; // [R01]
    case (ctl.mode)
      TPC_M_IC: begin
        cap_evt = (st.els[0] && i_ch_pin && !st.prev_in) || // [R02]
                  (st.els[1] && !i_ch_pin && st.prev_in);
        if (cap_evt) begin
          next_st.cv   = st.cnt; // [R23]
          next_st.flag = 1'b1;   // [R23]
          next_st.arm  = 1'b0;
        end
      end
      TPC_M_OC: begin
        if (cmp_hit) begin
          next_st.flag = 1'b1;
          next_st.arm  = 1'b0;
          case (st.els)
            2'h1:    next_st.pin = ~st.pin; // [R03]
            2'h2:    next_st.pin = 1'b0;    // [R03]
            2'h3:    next_st.pin = 1'b1;    // [R03]
            default: next_st.pin = st.pin;  // [R03]
          endcase
        end
      end
      default: begin
        // Both PWM kinds: high for code 10, low for X1, while the count is below the duty value.
        next_st.pin = (next_st.cnt < st.cv) ^ st.els[0]; // [R04] [R05]
        if (cmp_hit && st.cv != 16'h0000 && st.cv <= top) begin
          next_st.flag = 1'b1;
          next_st.arm  = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st      <= '0; // [R06] [R19]
      st.cv   <= `TPC_CV_RST; // [R06]
      st.modv <= `TPC_MOD_RST;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence seq_ic_read_hi;
    i_rd && i_addr == `TPC_A_CV_H && is_ic && !dbg && st.rd == TPC_RD_NONE;
  endsequence

  sequence seq_ic_read_lo;
    i_rd && i_addr == `TPC_A_CV_L && is_ic && !dbg && !cap_evt;
  endsequence

  chk_release_pin_oe: assert property ( // [R01]
    (st.els == `TPC_ELS_OFF) |=> !o_ch_oe)
    else $error("Pin still driven with edge/level code 00.");

  chk_read_pair_latched: assert property ( // [R07]
    seq_ic_read_hi ##1 !(i_wr && i_addr == `TPC_A_CSC) ##1 seq_ic_read_lo
    |=> o_rdata == $past(st.cv[7:0], 3))
    else $error("Second byte of a capture read is not the latched value.");

  chk_csc_resets_seq: assert property ( // [R08]
    (i_wr && i_addr == `TPC_A_CSC) |=> st.wr == TPC_WR_NONE && st.rd == TPC_RD_NONE)
    else $error("Control write did not restart byte sequences.");

  chk_ic_write_ignored: assert property ( // [R09]
    (wr_cv && is_ic && !cap_evt) |=> $stable(st.cv))
    else $error("Channel value changed by a write in capture mode.");

  chk_debug_read_frozen: assert property ( // [R10]
    (dbg && !(i_wr && i_addr == `TPC_A_CSC)) |=> $stable(st.rd) && $stable(st.rbuf))
    else $error("Read latch moved while debug was active.");

  chk_unclocked_load: assert property ( // [R11]
    (wr_cv && !hi && !is_ic && !dbg && st.wr == TPC_WR_HI && st.clks == TPC_CK_NONE)
    |=> st.cv == {$past(st.wbuf[15:8]), $past(i_wdata)} && st.wr == TPC_WR_NONE)
    else $error("Second byte did not load the pair at once.");

  chk_oc_tick_load: assert property ( // [R12]
    (st.wr == TPC_WR_BOTH && ctl.mode == TPC_M_OC && ctl.tick && !wr_cv)
    |=> st.cv == $past(st.wbuf) && st.wr == TPC_WR_NONE)
    else $error("Completed compare value not loaded at the counter step.");

  chk_capture_counter: assert property ( // [R23]
    cap_evt |=> st.cv == $past(st.cnt) && o_ch_flag)
    else $error("Capture did not store the counter and set the flag.");

  chk_stopped_counter: assert property ( // [R20]
    (st.clks == TPC_CK_NONE && !(i_wr && (i_addr == `TPC_A_CNT_H || i_addr == `TPC_A_CNT_L)))
    |=> $stable(st.cnt))
    else $error("Counter moved with no clock selected.");

  chk_reset_clears: assert property (disable iff (1'b0) // [R06] [R19]
    i_reset |=> st.cv == `TPC_CV_RST && st.clks == TPC_CK_NONE)
    else $error("Reset did not clear channel value and clock select.");
endmodule
`default_nettype wire

// File: include/tpc_defines.svh
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// Register offsets on the byte-wide register port.
`define TPC_A_TSC    3'h0
`define TPC_A_CNT_H  3'h1
`define TPC_A_CNT_L  3'h2
`define TPC_A_MOD_H  3'h3
`define TPC_A_MOD_L  3'h4
`define TPC_A_CSC    3'h5
`define TPC_A_CV_H   3'h6
`define TPC_A_CV_L   3'h7

// Timer status/control fields.
`define TPC_TSC_CENTER_PWM_SELECT 5
`define TPC_TSC_CLKS  4:3
`define TPC_TSC_PRESC 2:0

// Channel status/control fields.
`define TPC_CSC_FLAG 7
`define TPC_CSC_IE   6
`define TPC_CSC_MS   5:4
`define TPC_CSC_ELS  3:2

// Reset values and counter limits.
`define TPC_CV_RST    16'h0000
`define TPC_MOD_RST   16'h0000
`define TPC_FREE_TOP  16'hFFFF
`define TPC_ELS_OFF   2'h0

`endif

// File: include/tpc_pkg.sv
package tpc_pkg;

  typedef enum logic [1:0] {
    TPC_M_IC   = 2'h0,
    TPC_M_OC   = 2'h1,
    TPC_M_EDGE_PWM_MODE = 2'h3,
    TPC_M_CENTER_PWM_MODE = 2'h2
  } tpc_mode_t;

  typedef enum logic [1:0] {
    TPC_CK_NONE  = 2'h0,
    TPC_CK_BUS   = 2'h1,
    TPC_CK_FIXED = 2'h2,
    TPC_CK_EXT   = 2'h3
  } tpc_clks_t;

  // Write coherency sequence.
  typedef enum logic [1:0] {
    TPC_WR_NONE = 2'h0,
    TPC_WR_HI   = 2'h1,
    TPC_WR_BOTH = 2'h3,
    TPC_WR_LO   = 2'h2
  } tpc_wr_t;

  // Read coherency sequence.
  typedef enum logic [1:0] {
    TPC_RD_NONE = 2'h0,
    TPC_RD_HI   = 2'h1,
    TPC_RD_LO   = 2'h2,
    TPC_RD_SPR  = 2'h3
  } tpc_rd_t;

  typedef struct packed {
    logic        center_pwm_select;
    tpc_clks_t   clks;
    logic [2:0]  presc;
    logic [15:0] cnt;
    logic        down;
    logic [15:0] modv;
    logic        flag;
    logic        arm;
    logic        ie;
    logic [1:0]  ms;
    logic [1:0]  els;
    logic [15:0] cv;
    logic [15:0] wbuf;
    logic [15:0] rbuf;
    tpc_wr_t     wr;
    tpc_rd_t     rd;
    logic        pin;
    logic        oe;
    logic        prev_in;
    logic [7:0]  rdata;
  } tpc_state_t;

  typedef struct packed {
    logic       ext_q1;
    logic       ext_q2;
    logic       ext_q3;
    logic       fix_q1;
    logic       fix_q2;
    logic       fix_q3;
    logic [6:0] pre;
  } tpc_clk_state_t;

endpackage

// File: include/tpc_ctl_if.sv
`timescale 1ns/100ps
`default_nettype none
interface tpc_ctl_if;
  tpc_pkg::tpc_clks_t clks;
  logic [2:0]         presc;
  logic               tick;
  logic               center_pwm_select;
  logic [1:0]         ms;
  tpc_pkg::tpc_mode_t mode;
  modport clk_src  (input clks, input presc, output tick);
  modport dec      (input center_pwm_select, input ms, output mode);
  modport user     (output clks, output presc, input tick,
                    output center_pwm_select, output ms, input mode);
endinterface
`default_nettype wire

// File: logic/tpc_clk_sel.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_clk_sel (
  // Clock and reset.
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  // Clock sources.
  input  wire logic  i_ext_clk,
  input  wire logic  i_fixed_clk,
  input  wire logic  i_fll_engaged,
  // Control side.
  tpc_ctl_if.clk_src ctl
);
  import tpc_pkg::*;

  tpc_clk_state_t st;
  tpc_clk_state_t next_st;
  logic           src_edge;
  logic [6:0]     mask;

  always_comb begin
    next_st        = st;
    next_st.ext_q1 = i_ext_clk;
    next_st.ext_q2 = st.ext_q1;
    next_st.ext_q3 = st.ext_q2;
    next_st.fix_q1 = i_fixed_clk;
    next_st.fix_q2 = st.fix_q1;
    next_st.fix_q3 = st.fix_q2;
    mask           = 7'((8'h01 << ctl.presc) - 8'h01);
    case (ctl.clks)
      TPC_CK_BUS:   src_edge = 1'b1;
      // Without an engaged loop the fixed clock is the bus clock itself.
      TPC_CK_FIXED: src_edge = i_fll_engaged ? (st.fix_q2 & ~st.fix_q3) : 1'b1; // [R22]
      TPC_CK_EXT:   src_edge = st.ext_q2 & ~st.ext_q3; // [R21]
      default:      src_edge = 1'b0; // [R18]
    endcase
    if (src_edge) begin
      next_st.pre = 7'(st.pre + 7'h01);
    end
    ctl.tick = src_edge && ((st.pre & mask) == mask); // [R16]
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  chk_ext_edge_sync: assert property (@(posedge i_clk) disable iff (i_reset) // [R21]
    (ctl.clks == TPC_CK_EXT && ctl.tick) |-> $past(st.ext_q1) && !$past(st.ext_q1, 2))
    else $error("External tick without a synchronised rising edge.");
endmodule
`default_nettype wire

// File: logic/tpc_mode_dec.sv
`timescale 1ns/100ps
`default_nettype none
module tpc_mode_dec (
  // Control side.
  tpc_ctl_if.dec ctl
);
  import tpc_pkg::*;

  always_comb begin
    if (ctl.center_pwm_select) begin
      ctl.mode = TPC_M_CENTER_PWM_MODE; // [R05] [R17]
    end else if (ctl.ms[1]) begin
      ctl.mode = TPC_M_EDGE_PWM_MODE; // [R04]
    end else if (ctl.ms[0]) begin
      ctl.mode = TPC_M_OC; // [R03]
    end else begin
      ctl.mode = TPC_M_IC; // [R02]
    end
  end
endmodule
`default_nettype wire

// File: bench/tpc_channel_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "tpc_defines.svh"
module tpc_channel_tb;
  logic       i_clk;
  logic       i_reset;
  logic [2:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic       i_debug_active;
  logic       i_ext_clk;
  logic       i_fixed_clk;
  logic       i_fll_engaged;
  logic       i_ch_pin;
  logic       o_ch_pin;
  logic       o_ch_oe;
  logic       o_ch_flag;
  int         errors;
  int         cmp_count;
  int         cycles;
  logic [7:0] rv;
  logic       p;
  int         h1;
  int         h2;

  tpc_channel dut (
    .i_clk          (i_clk),
    .i_reset        (i_reset),
    .i_addr         (i_addr),
    .i_wdata        (i_wdata),
    .i_wr           (i_wr),
    .i_rd           (i_rd),
    .o_rdata        (o_rdata),
    .i_debug_active (i_debug_active),
    .i_ext_clk      (i_ext_clk),
    .i_fixed_clk    (i_fixed_clk),
    .i_fll_engaged  (i_fll_engaged),
    .i_ch_pin       (i_ch_pin),
    .o_ch_pin       (o_ch_pin),
    .o_ch_oe        (o_ch_oe),
    .o_ch_flag      (o_ch_flag)
  );

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // The run is about a thousand cycles; the ceiling only catches a hang.
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask

  task automatic chkn(input int g, input int e);
    chk8(8'(g), 8'(e));
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk8(d, e);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // Pulses on both slow clock inputs stay at an eighth of the bus rate.
  task automatic ext_pulses(input int n);
    repeat (n) begin
      @(posedge i_clk);
      i_ext_clk   <= 1'b1;
      i_fixed_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_ext_clk   <= 1'b0;
      i_fixed_clk <= 1'b0;
      repeat (3) @(posedge i_clk);
    end
    repeat (6) @(posedge i_clk);
  endtask

  task automatic pin_to(input logic v);
    @(posedge i_clk);
    i_ch_pin <= v;
    wait_cyc(4);
  endtask

  task automatic set_dbg(input logic v);
    @(posedge i_clk);
    i_debug_active <= v;
  endtask

  task automatic clear_csc(input logic [7:0] d);
    rd(`TPC_A_CSC, rv);
    wr(`TPC_A_CSC, d);
  endtask

  task automatic count_hi(input int n, output int h);
    h = 0;
    repeat (n) begin
      @(posedge i_clk);
      #1 if (o_ch_pin === 1'b1) h++;
    end
  endtask

  task automatic t_reset();
    rdchk(`TPC_A_CV_H, 8'h00);
    rdchk(`TPC_A_CV_L, 8'h00);
    rdchk(`TPC_A_TSC, 8'h00);
    chk1(o_ch_oe, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_write();
    wr(`TPC_A_CSC, 8'h10);
    wr(`TPC_A_CV_H, 8'h12);
    rdchk(`TPC_A_CV_H, 8'h00);
    wr(`TPC_A_CV_L, 8'h34);
    rdchk(`TPC_A_CV_H, 8'h12);
    rdchk(`TPC_A_CV_L, 8'h34);
    wr(`TPC_A_CV_H, 8'h56);
    wr(`TPC_A_CSC, 8'h10);
    wr(`TPC_A_CV_L, 8'h78);
    rdchk(`TPC_A_CV_L, 8'h34);
    wr(`TPC_A_CV_H, 8'h56);
    rdchk(`TPC_A_CV_H, 8'h56);
    rdchk(`TPC_A_CV_L, 8'h78);
    wr(`TPC_A_CV_L, 8'h11);
    set_dbg(1'b1);
    wr(`TPC_A_CV_H, 8'h9A);
    rdchk(`TPC_A_CV_H, 8'h9A);
    rdchk(`TPC_A_CV_L, 8'h78);
    set_dbg(1'b0);
    wr(`TPC_A_CV_H, 8'h22);
    rdchk(`TPC_A_CV_H, 8'h22);
    rdchk(`TPC_A_CV_L, 8'h11);
    chk1(o_ch_oe, 1'b0);
    $display("test write done");
  endtask

  task automatic t_capture();
    wr(`TPC_A_CSC, 8'h04);
    wr(`TPC_A_CV_H, 8'hAA);
    rdchk(`TPC_A_CV_H, 8'h22);
    rdchk(`TPC_A_CV_L, 8'h11);
    for (int e = 1; e < 4; e++) begin
      clear_csc({4'h0, 2'(e), 2'b00});
      pin_to(1'b1);
      chk1(o_ch_flag, 1'(e & 1));
      clear_csc({4'h0, 2'(e), 2'b00});
      pin_to(1'b0);
      chk1(o_ch_flag, 1'(e >> 1));
    end
    clear_csc(8'h04);
    rdchk(`TPC_A_CV_L, 8'h00);
    wr(`TPC_A_TSC, 8'h18);
    ext_pulses(5);
    wr(`TPC_A_TSC, 8'h00);
    ext_pulses(2);
    rdchk(`TPC_A_CNT_H, 8'h00);
    rdchk(`TPC_A_CNT_L, 8'h05);
    pin_to(1'b1);
    chk1(o_ch_flag, 1'b1);
    rdchk(`TPC_A_CV_H, 8'h00);
    rdchk(`TPC_A_CV_H, 8'h00);
    rdchk(`TPC_A_CV_L, 8'h05);
    rdchk(`TPC_A_CV_H, 8'h00);
    wr(`TPC_A_TSC, 8'h18);
    ext_pulses(3);
    wr(`TPC_A_TSC, 8'h00);
    pin_to(1'b0);
    pin_to(1'b1);
    set_dbg(1'b1);
    rdchk(`TPC_A_CV_L, 8'h08);
    set_dbg(1'b0);
    rdchk(`TPC_A_CV_L, 8'h05);
    @(posedge i_clk);
    i_fll_engaged <= 1'b1;
    wr(`TPC_A_TSC, 8'h10);
    ext_pulses(2);
    wr(`TPC_A_TSC, 8'h00);
    rdchk(`TPC_A_CNT_L, 8'h0A);
    $display("test capture done");
  endtask

  task automatic t_compare();
    clear_csc(8'h1C);
    wr(`TPC_A_CV_H, 8'h00);
    wr(`TPC_A_CV_L, 8'h08);
    wr(`TPC_A_MOD_H, 8'h00);
    wr(`TPC_A_MOD_L, 8'h10);
    wr(`TPC_A_CNT_H, 8'h00);
    rdchk(`TPC_A_CSC, 8'h1C);
    wr(`TPC_A_TSC, 8'h08);
    wait_cyc(40);
    chk1(o_ch_pin, 1'b1);
    chk1(o_ch_oe, 1'b1);
    chk1(o_ch_flag, 1'b1);
    wr(`TPC_A_CSC, 8'h18);
    wait_cyc(40);
    chk1(o_ch_pin, 1'b0);
    wr(`TPC_A_CSC, 8'h14);
    wait_cyc(20);
    p = o_ch_pin;
    wait_cyc(17);
    chk1(o_ch_pin, ~p);
    wr(`TPC_A_CV_H, 8'h00);
    wr(`TPC_A_CV_L, 8'h03);
    rdchk(`TPC_A_CV_L, 8'h03);
    wr(`TPC_A_CV_L, 8'h08);
    wr(`TPC_A_CV_H, 8'h00);
    rdchk(`TPC_A_CV_L, 8'h08);
    wr(`TPC_A_CSC, 8'h10);
    wait_cyc(1);
    p = o_ch_pin;
    wait_cyc(40);
    chk1(o_ch_pin, p);
    chk1(o_ch_oe, 1'b0);
    $display("test compare done");
  endtask

  task automatic t_pwm();
    wr(`TPC_A_CSC, 8'h28);
    wait_cyc(20);
    count_hi(68, h1);
    chkn(h1, 32);
    wr(`TPC_A_CSC, 8'h24);
    wait_cyc(20);
    count_hi(68, h1);
    chkn(h1, 36);
    wr(`TPC_A_CV_H, 8'h00);
    wr(`TPC_A_CV_L, 8'h04);
    wait_cyc(40);
    count_hi(68, h1);
    chkn(h1, 52);
    wr(`TPC_A_TSC, 8'h28);
    wr(`TPC_A_CSC, 8'h28);
    wait_cyc(70);
    count_hi(64, h1);
    wr(`TPC_A_CSC, 8'h24);
    wait_cyc(70);
    count_hi(64, h2);
    chkn(h1 + h2, 64);
    chk1(h1 >= 12 && h1 <= 18, 1'b1);
    $display("test pwm done");
  endtask

  initial begin
    errors         = 0;
    cmp_count      = 0;
    cycles         = 0;
    i_reset        = 1'b1;
    i_addr         = 3'h0;
    i_wdata        = 8'h00;
    i_wr           = 1'b0;
    i_rd           = 1'b0;
    i_debug_active = 1'b0;
    i_ext_clk      = 1'b0;
    i_fixed_clk    = 1'b0;
    i_fll_engaged  = 1'b0;
    i_ch_pin       = 1'b0;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    t_reset();
    t_write();
    t_capture();
    t_compare();
    t_pwm();
    give_verdict();
  end
endmodule
`default_nettype wire
